/* File: rtl/host_jtag_pin_sharing.sv */
/*
  Shared control pin mux for a serializer: routes the chip-select, serial
  input, serial output and serial clock pins to either the host serial
  register interface or the boundary-scan port, and applies the reset pin.
  Assumes the host interface and the test access port live elsewhere on the
  chip; the shared serial clock arrives as its own clock port and may stop
  between transfers, and the core clock runs whenever the static pins move.
  Assumes the pad ring turns each enable output into a real tri-state driver.
*/
// Functional notes
// - In host mode a low reset pin puts all blocks at defaults and floats every I/O, video outputs included.
// - In test mode a low reset pin puts all blocks at defaults and holds the test state machine in reset.
// - In test mode a high reset pin lets the test state machine run again.
// - A high mode select routes the four shared pins to the boundary-scan port.
// - A low mode select routes the four shared pins to the host serial interface.
// - In host mode the shared select pin is an active-low chip select.
// - In test mode the shared select pin is the active-high test mode select.
// - In host mode the shared output pin carries register read data.
// - In test mode the shared output pin carries test data out.
// - In host mode the shared clock pin is the burst clock for all words.

module host_jtag_pin_sharing (
  // Core clock and reset.
  input  wire logic                      clk,
  input  wire logic                      rst,
  // Shared serial clock, the link-side clock domain.
  input  wire logic                      serial_clk,
  // Static device pins.
  input  wire logic                      reset_pin_n,
  input  wire logic                      test_host_sel,
  // Shared pins toward the outside.
  input  wire pin_share_pkg::shared_in_t shared_in,
  output pin_share_pkg::drive_t          serial_out_or_test_out,
  // Host serial interface side.
  output pin_share_pkg::host_side_t      host_side,
  input  wire logic                      host_serial_output,
  input  wire logic                      host_serial_output_en,
  // Boundary-scan port side.
  output pin_share_pkg::tap_side_t       tap_side,
  output logic                           tap_reset_n,
  input  wire logic                      tap_data_out,
  input  wire logic                      tap_data_out_en,
  // Chip-wide controls.
  output logic                           func_defaults,
  output logic                           io_hiz,
  output logic                           serial_video_output_en
);

  // Mode decode shared by both clock domains, so they can never disagree on it.
  function automatic logic is_test_mode(input pin_share_pkg::pin_mode_t mode);
    return (mode == pin_share_pkg::MODE_TEST);
  endfunction : is_test_mode

  // Steers one shared signal to the side that owns the pins.
  function automatic logic pick_side(input logic test_mode, input logic test_val, input logic host_val);
    return test_mode ? test_val : host_val;
  endfunction : pick_side

  // Filtered static pins in the core domain.
  logic reset_level;
  logic select_level;

  // Starts low, so the chip stays at defaults until the pin is seen high.
  pin_level_filter #(
    .RESET_VALUE (pin_share_pkg::RST_PIN_RESET_N)
  ) u_reset_filter (
    .clk       (clk),
    .rst       (rst),
    .pin_in    (reset_pin_n),
    .level_out (reset_level)
  );

  // Starts in host mode, which matches the mode register's reset value.
  pin_level_filter #(
    .RESET_VALUE (pin_share_pkg::RST_SELECT_TEST)
  ) u_select_filter (
    .clk       (clk),
    .rst       (rst),
    .pin_in    (test_host_sel),
    .level_out (select_level)
  );

  // Core-domain decode of mode and reset pin. The controls decode from the
  // filtered mode, not from mode_ff, so they switch in the same cycle as the
  // mode register and no cycle mixes the old mode with the new reset level.
  pin_share_pkg::pin_mode_t mode_ff;
  pin_share_pkg::pin_mode_t nxt_mode;
  logic                     func_default_ff;
  logic                     io_hiz_ff;
  logic                     tap_reset_n_ff;
  logic                     video_en_ff;
  wire                      pin_reset_low;
  wire                      nxt_io_hiz;
  wire                      nxt_tap_reset_n;

  assign nxt_mode        = select_level ? pin_share_pkg::MODE_TEST : pin_share_pkg::MODE_HOST;
  assign pin_reset_low   = ~reset_level;
  assign nxt_io_hiz      = pin_reset_low && !is_test_mode(nxt_mode);
  assign nxt_tap_reset_n = ~(pin_reset_low && is_test_mode(nxt_mode));

  // Registered chip-wide controls; the reset pin forces defaults in both modes.
  // Only host mode floats the I/O, so boundary scan can still drive the pins.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_ff         <= pin_share_pkg::MODE_HOST;
      func_default_ff <= pin_share_pkg::RST_FUNC_DEFAULT;
      io_hiz_ff       <= pin_share_pkg::RST_IO_HIZ;
      tap_reset_n_ff  <= pin_share_pkg::RST_TAP_RESET_N;
      video_en_ff     <= pin_share_pkg::RST_VIDEO_EN;
    end else begin
      mode_ff         <= nxt_mode;
      func_default_ff <= pin_reset_low;
      io_hiz_ff       <= nxt_io_hiz;
      tap_reset_n_ff  <= nxt_tap_reset_n;
      video_en_ff     <= ~nxt_io_hiz;
    end
  end

  // Outputs come straight from the flops above, so no decode glitch leaves the block.
  assign func_defaults          = func_default_ff;
  assign io_hiz                 = io_hiz_ff;
  assign tap_reset_n            = tap_reset_n_ff;
  assign serial_video_output_en = video_en_ff;

  // The link domain is held in reset while I/O must float. The serial clock
  // may be stopped then, so only an asynchronous clear can float the pin.
  // io_hiz_ff is a flop, so this reset term is glitch free.
  wire                                        link_rst_raw;
  logic [pin_share_pkg::LINK_SYNC_STAGES-1:0] link_rst_sync_ff;
  wire                                        link_rst;

  assign link_rst_raw = rst | io_hiz_ff;

  // Entry into reset is immediate, but the release is retimed to the serial
  // clock so that no link flop leaves reset close to one of its edges. The
  // price is that the first two serial clocks after the pins stop floating
  // are spent in reset; the far side idles through them anyway.
  always_ff @(posedge serial_clk or posedge link_rst_raw) begin
    if (link_rst_raw) begin
      link_rst_sync_ff <= '1;
    end else begin
      link_rst_sync_ff <= {link_rst_sync_ff[0], 1'b0};
    end
  end

  assign link_rst = link_rst_sync_ff[pin_share_pkg::LINK_SYNC_STAGES-1];

  // Mode crosses into the link domain as a level; keeps it static
  // during transfers, so two flops are enough. A change in mid-transfer may
  // hand one bit to the old side and the next to the new one.
  logic [pin_share_pkg::LINK_SYNC_STAGES-1:0] mode_sync_ff;
  wire                                        link_test_mode;

  always_ff @(posedge serial_clk or posedge link_rst) begin
    if (link_rst) begin
      mode_sync_ff <= '0;
    end else begin
      mode_sync_ff <= {mode_sync_ff[0], is_test_mode(mode_ff)};
    end
  end

  // Only the second flop is read, so the first may settle for a whole period.
  assign link_test_mode = mode_sync_ff[pin_share_pkg::LINK_SYNC_STAGES-1];

  // Input routing: the deselected side sees its idle levels, so a host
  // stays deselected in test mode and the test port sees TMS high in host mode.
  // TMS held high walks the test state machine to its reset state, so a later
  // switch to test mode starts from a known state.
  pin_share_pkg::host_side_t host_side_ff;
  pin_share_pkg::host_side_t nxt_host_side;
  pin_share_pkg::tap_side_t  tap_side_ff;
  pin_share_pkg::tap_side_t  nxt_tap_side;

  assign nxt_host_side.chip_sel_n        = pick_side(link_test_mode, 1'b1, shared_in.select_pin);
  assign nxt_host_side.host_serial_input = pick_side(link_test_mode, 1'b1, shared_in.data_pin);
  assign nxt_tap_side.test_select        = pick_side(link_test_mode, shared_in.select_pin, 1'b1);
  assign nxt_tap_side.test_data_in       = pick_side(link_test_mode, shared_in.data_pin, 1'b1);

  // Inputs are sampled on the rising edge of the shared clock.
  always_ff @(posedge serial_clk or posedge link_rst) begin
    if (link_rst) begin
      host_side_ff <= '{chip_sel_n: pin_share_pkg::RST_CHIP_SEL_N,
                        host_serial_input: pin_share_pkg::RST_DATA_IN};
      tap_side_ff  <= '{test_select: pin_share_pkg::RST_TEST_SELECT,
                        test_data_in: pin_share_pkg::RST_DATA_IN};
    end else begin
      host_side_ff <= nxt_host_side;
      tap_side_ff  <= nxt_tap_side;
    end
  end

  assign host_side = host_side_ff;
  assign tap_side  = tap_side_ff;

  // Output routing: shared serial output picks register data or test data.
  // The enable follows the owning side only; the side turned away can never
  // drive the shared pin, even if it raises its own enable.
  pin_share_pkg::drive_t out_ff;
  pin_share_pkg::drive_t nxt_out;

  assign nxt_out.level  = pick_side(link_test_mode, tap_data_out, host_serial_output);
  assign nxt_out.enable = pick_side(link_test_mode, tap_data_out_en, host_serial_output_en);

  // Output launches on the falling edge so it is stable at the far end's
  // rising sample edge.
  always_ff @(negedge serial_clk or posedge link_rst) begin
    if (link_rst) begin
      out_ff <= '{level: pin_share_pkg::RST_SERIAL_OUT, enable: pin_share_pkg::RST_SERIAL_OE};
    end else begin
      out_ff <= nxt_out;
    end
  end

  // Level and enable leave the block straight from the falling-edge flop.
  assign serial_out_or_test_out = out_ff;

endmodule : host_jtag_pin_sharing

/* File: rtl/pin_level_filter.sv */
/*
  Three-stage pin synchroniser with agreement filter.
  Assumes an asynchronous pin level and the core clock with active-high reset.
*/
module pin_level_filter #(
  parameter logic RESET_VALUE = 1'b0
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Raw pin and its filtered level.
  input  wire logic pin_in,
  output logic      level_out
);

  logic [pin_share_pkg::PIN_SYNC_STAGES-1:0] stage_ff;
  logic                                      level_ff;
  wire                                       agree;

  // A change is accepted only once the second and third stages match,
  // which rejects a level that flips inside the sampling window.
  assign agree     = (stage_ff[1] == stage_ff[2]);
  assign level_out = level_ff;

  // Shift chain; the first stage feeds only the second.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage_ff <= {pin_share_pkg::PIN_SYNC_STAGES{RESET_VALUE}};
      level_ff <= RESET_VALUE;
    end else begin
      stage_ff <= {stage_ff[1:0], pin_in};
      if (agree) begin
        level_ff <= stage_ff[2];
      end
    end
  end

endmodule : pin_level_filter

/* File: rtl/pin_share_pkg.sv */
/*
  Shared constants and types for the serial control pin sharing block.
  Assumes every design file names these items through the package scope.
*/
package pin_share_pkg;

  // Which agent owns the four shared serial pins.
  typedef enum logic {
    MODE_HOST = 1'b0,
    MODE_TEST = 1'b1
  } pin_mode_t;

  // Stages of the pin input filter and of the core-to-link level crossing.
  localparam int unsigned PIN_SYNC_STAGES  = 3;
  localparam int unsigned LINK_SYNC_STAGES = 2;

  // Values held after reset, before any pin level has been filtered.
  localparam logic RST_PIN_RESET_N  = 1'b0;
  localparam logic RST_SELECT_TEST  = 1'b0;
  localparam logic RST_FUNC_DEFAULT = 1'b1;
  localparam logic RST_IO_HIZ       = 1'b1;
  localparam logic RST_TAP_RESET_N  = 1'b0;
  localparam logic RST_CHIP_SEL_N   = 1'b1;
  localparam logic RST_TEST_SELECT  = 1'b1;
  localparam logic RST_DATA_IN      = 1'b1;
  localparam logic RST_SERIAL_OUT   = 1'b1;
  localparam logic RST_SERIAL_OE    = 1'b0;
  localparam logic RST_VIDEO_EN     = 1'b0;

  // Two pins sampled from the shared select and shared serial input.
  typedef struct packed {
    logic select_pin;
    logic data_pin;
  } shared_in_t;

  // Host serial register interface side of the mux.
  typedef struct packed {
    logic chip_sel_n;
    logic host_serial_input;
  } host_side_t;

  // Boundary-scan port side of the mux.
  typedef struct packed {
    logic test_select;
    logic test_data_in;
  } tap_side_t;

  // One tri-state driver: level and enable.
  typedef struct packed {
    logic level;
    logic enable;
  } drive_t;

endpackage : pin_share_pkg

/* File: testbench/far_side_model.sv */
/* Far-side host or test controller that clocks frames onto the shared pins.
   Assumes the bench raises frame_go only while busy is low. */
module far_side_model (
  // Frame request from the bench.
  input  wire logic                 frame_go,
  input  wire logic [7:0]           frame_bits,
  output logic                      busy,
  // Shared pins toward the block.
  output logic                      serial_clk,
  output pin_share_pkg::shared_in_t shared_in
);
  timeunit 1ns / 100ps;
  // The clock stands still between frames and idle pins sit at their pull-up level.
  initial begin
    busy = 1'b0;
    serial_clk = 1'b0;
    shared_in = 2'h3;
  end
  // Two idle clocks let the mode cross, then eight bits, then one deselected clock.
  always @(posedge frame_go) begin
    busy = 1'b1;
    for (int i = 0; i < 11; i++) begin
      shared_in = (i < 2 || i > 9) ? 2'h3 : {1'b0, frame_bits[9-i]};
      #80 serial_clk = 1'b1;
      #80 serial_clk = 1'b0;
    end
    busy = 1'b0;
  end
endmodule : far_side_model

/* File: testbench/pin_share_chk.sv */
/* Assertions on the ports of the shared pin block.
   Assumes static pins settle in 8 core clocks and the mode in 5 link clocks. */
module pin_share_chk (
  // Clocks and reset.
  input wire logic                      clk,
  input wire logic                      rst,
  input wire logic                      serial_clk,
  // Static pins.
  input wire logic                      reset_pin_n,
  input wire logic                      test_host_sel,
  // Shared pins and the routed sides.
  input wire pin_share_pkg::shared_in_t shared_in,
  input wire pin_share_pkg::drive_t     serial_out_or_test_out,
  input wire pin_share_pkg::host_side_t host_side,
  input wire pin_share_pkg::tap_side_t  tap_side,
  // Chip-wide controls.
  input wire logic                      tap_reset_n,
  input wire logic                      func_defaults,
  input wire logic                      io_hiz,
  input wire logic                      serial_video_output_en
);
  timeunit 1ns / 100ps;
  // A mode only counts once it has held across five link clocks, to cover both crossings.
  sequence s_test; test_host_sel [*5]; endsequence
  sequence s_host; !test_host_sel [*5]; endsequence
  // Static pin decode, judged once the pin filter has surely settled; the output float check holds at every core clock.
  property p_host_rst; @(posedge clk) disable iff (rst) (!test_host_sel && !reset_pin_n) [*8] |->
    io_hiz && func_defaults && !serial_video_output_en; endproperty
  a_host_rst: assert property (p_host_rst) else $error("host reset");
  property p_hiz_out; @(posedge clk) disable iff (rst) io_hiz |-> !serial_out_or_test_out.enable; endproperty
  a_hiz_out: assert property (p_hiz_out) else $error("output floats");
  property p_host_run; @(posedge clk) disable iff (rst) (!test_host_sel && reset_pin_n) [*8] |->
    !io_hiz && !func_defaults; endproperty
  a_host_run: assert property (p_host_run) else $error("host run");
  property p_test_rst; @(posedge clk) disable iff (rst) (test_host_sel && !reset_pin_n) [*8] |->
    !tap_reset_n && func_defaults && !io_hiz; endproperty
  a_test_rst: assert property (p_test_rst) else $error("test reset");
  property p_test_run; @(posedge clk) disable iff (rst) (test_host_sel && reset_pin_n) [*8] |->
    tap_reset_n && !func_defaults; endproperty
  a_test_run: assert property (p_test_run) else $error("test run");
  // Link routing: the selected side shows the pins taken at the previous link edge, the other side its idle levels.
  property p_tap_route; @(posedge serial_clk) disable iff (rst || io_hiz) s_test |->
    tap_side == $past(shared_in); endproperty
  a_tap_route: assert property (p_tap_route) else $error("test route");
  property p_host_idle; @(posedge serial_clk) disable iff (rst || io_hiz) s_test |-> host_side == 2'h3; endproperty
  a_host_idle: assert property (p_host_idle) else $error("host idle");
  property p_host_route; @(posedge serial_clk) disable iff (rst || io_hiz) s_host |->
    host_side == $past(shared_in) && tap_side == 2'h3; endproperty
  a_host_route: assert property (p_host_route) else $error("host route");
endmodule : pin_share_chk

bind host_jtag_pin_sharing pin_share_chk u_chk (.clk, .rst, .serial_clk, .reset_pin_n, .test_host_sel, .shared_in,
  .serial_out_or_test_out, .host_side, .tap_side, .tap_reset_n, .func_defaults, .io_hiz, .serial_video_output_en);

/* File: testbench/tb_host_jtag_pin_sharing.sv */
/* Self-checking bench for the shared pin block.
   Assumes the far-side model and the bound checker are compiled alongside. */
module tb_host_jtag_pin_sharing;
  timeunit 1ns / 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reset_pin_n = 1'b0;
  logic test_host_sel = 1'b0;
  logic go = 1'b0;
  logic [7:0] bits = 8'h00;
  logic [7:0] cap = 8'h00;
  logic [3:0] src = 4'hd;
  logic busy, serial_clk, tap_reset_n, func_defaults, io_hiz, video_en;
  int err_count = 0;
  int n_compared = 0;
  pin_share_pkg::shared_in_t shared_in;
  pin_share_pkg::drive_t out;
  pin_share_pkg::host_side_t host_side;
  pin_share_pkg::tap_side_t tap_side;

  // Core clock and the block under test with its far side.
  always #5 clk = ~clk;
  far_side_model partner (.frame_go(go), .frame_bits(bits), .busy, .serial_clk, .shared_in);
  host_jtag_pin_sharing dut (.clk, .rst, .serial_clk, .reset_pin_n, .test_host_sel, .shared_in,
    .serial_out_or_test_out(out), .host_side, .host_serial_output(src[3]), .host_serial_output_en(src[2]),
    .tap_side, .tap_reset_n, .tap_data_out(src[1]), .tap_data_out_en(src[0]), .func_defaults, .io_hiz,
    .serial_video_output_en(video_en));

  // Shift in the bit routed to the selected side at every link edge.
  always @(posedge serial_clk) cap <= {cap[6:0], test_host_sel ? tap_side.test_data_in : host_side.host_serial_input};

  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask : chk

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // Static pins only change with no frame running, then get time to settle.
  task automatic pins(logic mode, logic rn);
    test_host_sel = mode;
    reset_pin_n = rn;
    cyc(8);
  endtask : pins

  // One frame through the far side, waited for under a bound, then its bits compared.
  task automatic frame(logic [7:0] b);
    int n = 0;
    bits = b;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    while (busy !== 1'b0 && n < 400) begin
      cyc(1);
      n++;
    end
    chk("frame end", 8'h00, {7'h0, busy});
    chk("bits", b, cap);
  endtask : frame

  task automatic t_host;
    pins(1'b0, 1'b0);
    chk("host reset", 8'h0c, {4'h0, func_defaults, io_hiz, video_en, out.enable});
    pins(1'b0, 1'b1);
    frame(8'ha5);
    chk("host run", 8'h03, {4'h0, func_defaults, io_hiz, video_en, out.enable});
    chk("host out", 8'h01, {7'h0, out.level});
    chk("tap idle", 8'h03, {6'h0, tap_side});
  endtask : t_host

  // A one-clock dip on the reset pin is too short to be taken.
  task automatic t_glitch;
    reset_pin_n = 1'b0;
    cyc(1);
    reset_pin_n = 1'b1;
    cyc(8);
    chk("glitch", 8'h00, {7'h0, io_hiz});
  endtask : t_glitch

  task automatic t_test;
    src = 4'h3;
    pins(1'b1, 1'b0);
    chk("test reset", 8'h02, {5'h0, tap_reset_n, func_defaults, io_hiz});
    pins(1'b1, 1'b1);
    chk("test run", 8'h04, {5'h0, tap_reset_n, func_defaults, io_hiz});
    frame(8'h3c);
    chk("host idle", 8'h03, {6'h0, host_side});
    chk("test out", 8'h03, {6'h0, out});
  endtask : t_test

  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  // Main sequence after a twelve-clock reset.
  initial begin
    cyc(12);
    rst = 1'b0;
    t_host();
    t_glitch();
    t_test();
    stop_test();
  end

  // Watchdog well beyond the few microseconds the sequence needs.
  initial begin
    #20000;
    err_count++;
    stop_test();
  end
endmodule : tb_host_jtag_pin_sharing
